// ---- logic/mdus_sequencer.sv ----
`timescale 1ns/1ps
// Summary of operation
// - full reset only on reset falling edge
// - gain full-scale, offset zero, data zero
// - reset lasts 270 us, busy low
// - reset busy blocks writes and load strobes
// - after reset ignore level until next fall
// - clear loads clear code, 35 us
// - register write recomputes value, busy low
// - writes accepted during compute, no update
// - load strobe updates; stored during compute only
// - strobe held low updates on busy rise
// - update only channels written since strobe
// - sample queue enable at power-up/clear/reset
// - queue only in parallel mode
// - queue holds 128; writes when full dropped
// - busy low while queue executes, writes accepted
// - power-on: defaults, outputs hi-z, busy low
// - power-down keeps registers, hi-z or pulldown
// - straps choose parallel, spi or two-wire
// - interface wakes on write or sync fall
// - config bit set hi-z, clear pulldown
module mdus_sequencer
	import mdus_pkg::*;
#(
	parameter int RESET_CYC = MDUS_RESET_CYC,
	parameter int DEPTH = MDUS_QUEUE_DEPTH
)
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_reset_pin_n,
	input wire logic i_async_clear_input_n,
	input wire logic i_load_outputs_strobe_n,
	input wire logic i_queue_enable,
	input wire logic i_serial_parallel_select,
	input wire logic i_spi_i2c_select,
	input wire logic i_write_strobe_n,
	input wire logic i_frame_sync_n,
	input wire logic i_wr_valid,
	input wire mdus_instr_s i_wr_instr,
	input wire logic i_power_down,
	input wire logic i_powerdown_output_config_bit,
	input wire logic [11:0] i_clear_code,
	output logic o_busy_n,
	output logic o_outputs_hiz,
	output logic o_outputs_pulldown,
	output logic o_iface_awake,
	output mdus_mode_s o_mode,
	output logic o_queue_full,
	output logic [MDUS_CHANNELS*MDUS_DATA_W-1:0] o_dac_codes
);
	// counter also holds the clear time when the reset time is set short
	localparam int CMAX = (RESET_CYC > MDUS_CLEAR_CYC) ? RESET_CYC : MDUS_CLEAR_CYC;
	localparam int CW = $clog2(CMAX + 1);
	localparam int AW = $clog2(DEPTH);

	typedef enum {ST_POR, ST_RESET, ST_CLEAR, ST_IDLE, ST_CALC} mdus_state_e;

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] s1, s2, s3, s4, s5, s6, s7, s8;
	logic rst_pin, clear_pin, ld_pin, wr_pin, sync_pin, rst_pin_d, wr_d, sync_d;
	always_ff @(posedge i_sys_clk)
	begin
		s1 <= {s1[0], i_reset_pin_n};
		s2 <= {s2[0], i_async_clear_input_n};
		s3 <= {s3[0], i_load_outputs_strobe_n};
		s4 <= {s4[0], i_write_strobe_n};
		s5 <= {s5[0], i_frame_sync_n};
		s6 <= {s6[0], i_queue_enable};
		s7 <= {s7[0], i_serial_parallel_select};
		s8 <= {s8[0], i_spi_i2c_select};
		rst_pin_d <= s1[1];
		wr_d <= s4[1];
		sync_d <= s5[1];
	end
	assign rst_pin = s1[1];
	assign clear_pin = s2[1];
	assign ld_pin = s3[1];
	assign wr_pin = s4[1];
	assign sync_pin = s5[1];
	wire rst_fall = rst_pin_d & ~rst_pin; // edge only, level ignored
	wire clear_low = ~clear_pin;

	////////////////////////////////////////////////////////////////
	// state
	mdus_state_e state, next_state;
	logic [CW-1:0] cnt, next_cnt;
	logic ld_pending, next_ld_pending;
	logic qen, next_qen;
	logic hiz, next_hiz;
	logic [MDUS_CHANNELS-1:0] dirty, next_dirty;
	logic [MDUS_DATA_W-1:0] input_data_register [MDUS_CHANNELS];
	logic [MDUS_DATA_W-1:0] gain [MDUS_CHANNELS];
	logic [MDUS_DATA_W-1:0] offs [MDUS_CHANNELS];
	logic [MDUS_DATA_W-1:0] corrected_dac_value [MDUS_CHANNELS];
	logic [MDUS_DATA_W-1:0] dac [MDUS_CHANNELS];
	logic [5:0] calc_ch, next_calc_ch;

	// queue storage, written in order and drained singly
	mdus_instr_s qmem [DEPTH];
	logic [AW:0] wptr, rptr, next_wptr, next_rptr;
	wire [AW:0] qcount = wptr - rptr;
	wire qfull = (qcount == (AW+1)'(DEPTH));
	wire qempty = (wptr == rptr);
	wire parallel = ~s7[1]; // strap, synchronised like any pin
	wire use_q = qen & parallel;
	wire blocked = (state == ST_POR) | (state == ST_RESET);
	wire accept = i_wr_valid & ~blocked & ~(use_q & qfull);
	wire do_pop = use_q & ~qempty & (state == ST_IDLE);
	mdus_instr_s cur;
	logic cur_go;

	always_comb
	begin
		cur = use_q ? qmem[rptr[AW-1:0]] : i_wr_instr;
		cur_go = use_q ? do_pop : (accept & (state == ST_IDLE | state == ST_CALC));
	end

	////////////////////////////////////////////////////////////////
	// control next state
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_ld_pending = ld_pending;
		next_qen = qen;
		next_hiz = hiz;
		next_calc_ch = calc_ch;
		next_wptr = wptr;
		next_rptr = rptr;
		if (accept && use_q)
			next_wptr = wptr + 1'b1;
		if (do_pop)
			next_rptr = rptr + 1'b1;
		case (state)
			ST_POR, ST_RESET:
			begin
				next_hiz = (state == ST_POR);
				next_ld_pending = 1'b0;
				next_wptr = '0;
				next_rptr = '0;
				if (cnt == '0)
				begin
					next_state = ST_IDLE;
					next_qen = s6[1];
					next_hiz = 1'b0;
				end
				else
					next_cnt = cnt - 1'b1;
			end
			ST_CLEAR:
			begin
				if (cnt == '0)
				begin
					next_state = ST_IDLE;
					next_qen = s6[1];
				end
				else
					next_cnt = cnt - 1'b1;
			end
			ST_CALC:
			begin
				if (!ld_pin)
					next_ld_pending = 1'b1; // stored while busy
				if (cnt == '0)
					next_state = ST_IDLE;
				else
					next_cnt = cnt - 1'b1;
			end
			ST_IDLE:
			begin
				next_ld_pending = 1'b0;
				if (cur_go)
				begin
					next_state = ST_CALC;
					next_cnt = CW'(MDUS_CALC_CYC - 1);
					next_calc_ch = cur.channel;
				end
			end
			default:
				next_state = ST_POR;
		endcase
		if (state != ST_POR && state != ST_RESET && clear_low)
		begin
			next_state = ST_CLEAR;
			next_cnt = CW'(MDUS_CLEAR_CYC - 1);
		end
		if (rst_fall && state != ST_POR)
		begin
			next_state = ST_RESET;
			next_cnt = CW'(RESET_CYC - 1);
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			state <= ST_POR;
			cnt <= CW'(RESET_CYC - 1);
			ld_pending <= 1'b0;
			qen <= 1'b0;
			hiz <= 1'b1;
			calc_ch <= '0;
			wptr <= '0;
			rptr <= '0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			ld_pending <= next_ld_pending;
			qen <= next_qen;
			hiz <= next_hiz;
			calc_ch <= next_calc_ch;
			wptr <= next_wptr;
			rptr <= next_rptr;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (accept && use_q)
			qmem[wptr[AW-1:0]] <= i_wr_instr;
	end

	////////////////////////////////////////////////////////////////
	// per-channel registers
	wire init = blocked;
	wire load_now = (state == ST_IDLE) && (!ld_pin || ld_pending) && !cur_go;
	always_comb
	begin
		next_dirty = dirty;
		if (load_now)
			next_dirty = '0;
		if (state == ST_CALC && cnt == '0)
			next_dirty[calc_ch] = 1'b1;
		if (init || state == ST_CLEAR)
			next_dirty = '0;
	end
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
			dirty <= '0;
		else
			dirty <= next_dirty;
	end

	genvar g;
	generate
		for (g = 0; g < MDUS_CHANNELS; g++)
		begin : gch
			logic [23:0] prod;
			logic [12:0] sum;
			always_comb
			begin
				prod = input_data_register[g] * ({12'h000, gain[g]} + 24'h1);
				sum = {1'b0, prod[23:12]} + {1'b0, offs[g]};
			end
			always_ff @(posedge i_sys_clk)
			begin
				if (!i_rst_n || init)
				begin
					input_data_register[g] <= MDUS_DATA_RST;
					gain[g] <= MDUS_GAIN_RST;
					offs[g] <= MDUS_OFFS_RST;
					corrected_dac_value[g] <= MDUS_DATA_RST;
					dac[g] <= MDUS_DATA_RST;
				end
				else if (state == ST_CLEAR)
					dac[g] <= i_clear_code;
				else
				begin
					if (cur_go && cur.channel == 6'(g))
					begin
						if (cur.sel == MDUS_REG_DATA)
							input_data_register[g] <= cur.value;
						if (cur.sel == MDUS_REG_GAIN)
							gain[g] <= cur.value;
						if (cur.sel == MDUS_REG_OFFS)
							offs[g] <= cur.value;
					end
					if (state == ST_CALC && cnt == '0 && calc_ch == 6'(g))
						corrected_dac_value[g] <= sum[12] ? 12'hFFF : sum[11:0];
					if (load_now && dirty[g])
						dac[g] <= corrected_dac_value[g];
				end
			end
			always_ff @(posedge i_sys_clk)
				o_dac_codes[g*MDUS_DATA_W +: MDUS_DATA_W] <= dac[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// outputs; registers persist through power-down
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			o_busy_n <= 1'b0;
			o_outputs_hiz <= 1'b1;
			o_outputs_pulldown <= 1'b0;
			o_iface_awake <= 1'b0;
			o_mode <= '0;
			o_queue_full <= 1'b0;
		end
		else
		begin
			o_busy_n <= (next_state == ST_IDLE) && !(use_q && (next_wptr != next_rptr));
			o_outputs_hiz <= hiz || (i_power_down && i_powerdown_output_config_bit);
			o_outputs_pulldown <= !hiz && i_power_down && !i_powerdown_output_config_bit;
			o_iface_awake <= (wr_d & ~wr_pin) | (sync_d & ~sync_pin) | (o_iface_awake & i_wr_valid);
			o_mode <= '{parallel: parallel, two_wire: ~parallel & s8[1], queue_en: use_q};
			o_queue_full <= use_q && qfull;
		end
	end

	chk_busy_reset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		rst_fall && state == ST_IDLE |=> ##1 !o_busy_n) else $error("busy not low after reset edge");
	chk_no_load_reset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		blocked |=> dirty == '0) else $error("dirty set during reset");
	chk_clear_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state == ST_CLEAR |=> dac[0] == $past(i_clear_code)) else $error("clear code not loaded");
	chk_calc_busy: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state == ST_CALC |-> !o_busy_n) else $error("busy high during compute");
	chk_no_upd_busy: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state == ST_CALC && !clear_low |=> $stable(dac[0])) else $error("output moved while busy");
	chk_qfull_drop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		use_q && qfull && !do_pop |=> wptr == $past(wptr)) else $error("write into full queue");
	chk_pd_pull: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		!hiz && i_power_down && !i_powerdown_output_config_bit |=> o_outputs_pulldown) else $error("no pulldown");
	chk_por_hiz: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state == ST_POR |=> o_outputs_hiz) else $error("outputs not hi-z at power-on");
endmodule

// ---- pkg/mdus_pkg.sv ----
package mdus_pkg;
	localparam int MDUS_CLK_MHZ = 100;
	localparam int MDUS_RESET_TIME_US = 270;
	localparam int MDUS_RESET_CYC = MDUS_RESET_TIME_US * MDUS_CLK_MHZ;
	localparam int MDUS_CLEAR_TIME_US = 35;
	localparam int MDUS_CLEAR_CYC = MDUS_CLEAR_TIME_US * MDUS_CLK_MHZ;
	localparam int MDUS_CALC_CYC = 4;
	localparam int MDUS_CHANNELS = 40;
	localparam int MDUS_DATA_W = 12;
	localparam int MDUS_QUEUE_DEPTH = 128;
	localparam logic [11:0] MDUS_GAIN_RST = 12'hFFF;
	localparam logic [11:0] MDUS_OFFS_RST = 12'h000;
	localparam logic [11:0] MDUS_DATA_RST = 12'h000;
	localparam logic [11:0] MDUS_CLRCODE_RST = 12'h000;
	localparam logic MDUS_PD_HIZ_RST = 1'b1;
	localparam logic [1:0] MDUS_REG_DATA = 2'h3;
	localparam logic [1:0] MDUS_REG_OFFS = 2'h2;
	localparam logic [1:0] MDUS_REG_GAIN = 2'h1;
	localparam logic [1:0] MDUS_REG_SPECIAL = 2'h0;

	typedef struct packed
	{
		logic [5:0] channel;
		logic [1:0] sel;
		logic [11:0] value;
	} mdus_instr_s;

	typedef struct packed
	{
		logic parallel;
		logic two_wire;
		logic queue_en;
	} mdus_mode_s;
endpackage

// ---- verification/mdus_host_model.sv ----
`timescale 1ns/1ps
module mdus_host_model
	import mdus_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_go,
	input wire mdus_instr_s i_instr,
	input wire logic i_serial,
	input wire logic i_want_queue,
	output logic o_queue_enable,
	output logic o_wr_valid,
	output mdus_instr_s o_wr_instr,
	output logic o_write_strobe_n
);
	// board strap: queue only legal in parallel mode
	assign o_queue_enable = i_want_queue & ~i_serial;
	initial
	begin
		o_wr_valid = 1'b0;
		o_write_strobe_n = 1'b1;
		o_wr_instr = '0;
	end
	////////////////////////////////////////////////////////////
	// idle bus toggles so stale data never looks valid
	always @(posedge i_sys_clk)
	begin
		o_wr_valid <= i_go;
		o_write_strobe_n <= ~i_go;
		o_wr_instr <= i_go ? i_instr : ~o_wr_instr;
	end
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
	import mdus_pkg::*;
	localparam int RST_CYC = 20;
	logic i_sys_clk, i_rst_n, i_reset_pin_n, i_async_clear_input_n, i_load_outputs_strobe_n;
	logic i_serial_parallel_select, i_spi_i2c_select, i_power_down, i_powerdown_output_config_bit;
	logic [11:0] i_clear_code;
	logic go, want_q, qen, wr_valid, wr_n, o_busy_n, o_outputs_hiz, o_outputs_pulldown, o_iface_awake, o_queue_full;
	logic sync_n;
	mdus_instr_s instr, wr_instr;
	mdus_mode_s o_mode;
	logic [MDUS_CHANNELS*MDUS_DATA_W-1:0] o_dac_codes;
	int mismatches, cmp_count, cyc, k;
	`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
		$display("[FAIL] %s exp %h got %h", n, e, g); end end

	mdus_sequencer #(.RESET_CYC(RST_CYC)) u_mdus_sequencer (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_reset_pin_n(i_reset_pin_n), .i_async_clear_input_n(i_async_clear_input_n),
		.i_load_outputs_strobe_n(i_load_outputs_strobe_n), .i_queue_enable(qen),
		.i_serial_parallel_select(i_serial_parallel_select), .i_spi_i2c_select(i_spi_i2c_select),
		.i_write_strobe_n(wr_n), .i_frame_sync_n(sync_n), .i_wr_valid(wr_valid), .i_wr_instr(wr_instr),
		.i_power_down(i_power_down), .i_powerdown_output_config_bit(i_powerdown_output_config_bit),
		.i_clear_code(i_clear_code), .o_busy_n(o_busy_n), .o_outputs_hiz(o_outputs_hiz),
		.o_outputs_pulldown(o_outputs_pulldown), .o_iface_awake(o_iface_awake), .o_mode(o_mode),
		.o_queue_full(o_queue_full), .o_dac_codes(o_dac_codes));
	mdus_host_model u_mdus_host_model (.i_sys_clk(i_sys_clk), .i_go(go), .i_instr(instr),
		.i_serial(i_serial_parallel_select), .i_want_queue(want_q),
		.o_queue_enable(qen), .o_wr_valid(wr_valid), .o_wr_instr(wr_instr), .o_write_strobe_n(wr_n));
	////////////////////////////////////////////////////////////
	initial
	begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	// generous ceiling: clear wait plus draining a full queue
	always @(posedge i_sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////
	task close_out;
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic logic [11:0] code(input int ch);
		return o_dac_codes[ch*12 +: 12];
	endfunction
	task cycles(input int n);
		repeat (n) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
	endtask
	task wait_busy(input logic v, input int lim);
		k = 0;
		while (o_busy_n !== v && k < lim)
		begin
			@(negedge i_sys_clk);
			k++;
		end
		`CHK("busy_n", v, o_busy_n)
	endtask
	task wr(input logic [5:0] ch, input logic [11:0] v);
		@(posedge i_sys_clk);
		instr <= '{channel: ch, sel: MDUS_REG_DATA, value: v};
		go <= 1'b1;
		@(posedge i_sys_clk);
		go <= 1'b0;
	endtask
	task load;
		@(posedge i_sys_clk);
		i_load_outputs_strobe_n <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		i_load_outputs_strobe_n <= 1'b1;
		@(negedge i_sys_clk);
	endtask
	////////////////////////////////////////////////////////////
	task t_por;
		@(negedge i_sys_clk);
		`CHK("hiz", 1'b1, o_outputs_hiz)
		`CHK("busy_n", 1'b0, o_busy_n)
		`CHK("codes", '0, o_dac_codes)
		wait_busy(1'b1, RST_CYC + 10);
	endtask
	task t_update;
		wr(6'h05, 12'h5A3);
		load();
		`CHK("busy_n", 1'b0, o_busy_n)
		`CHK("code5", 12'h000, code(5))
		`CHK("awake", 1'b1, o_iface_awake)
		wait_busy(1'b1, 20);
		cycles(4);
		`CHK("code5", 12'h5A3, code(5))
		@(posedge i_sys_clk);
		i_load_outputs_strobe_n <= 1'b0;
		wr(6'h09, 12'h123);
		wait_busy(1'b0, 8);
		wait_busy(1'b1, 20);
		cycles(4);
		`CHK("code9", 12'h123, code(9))
		`CHK("code5", 12'h5A3, code(5))
		@(posedge i_sys_clk);
		i_load_outputs_strobe_n <= 1'b1;
	endtask
	task t_clear;
		@(posedge i_sys_clk);
		i_clear_code <= 12'hABC;
		i_async_clear_input_n <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		i_async_clear_input_n <= 1'b1;
		cycles(MDUS_CLEAR_CYC + 100);
		`CHK("code0", 12'hABC, code(0))
		`CHK("code39", 12'hABC, code(39))
		// clear left no channel dirty, so a strobe must not restore the computed 5A3
		load();
		cycles(4);
		`CHK("code5", 12'hABC, code(5))
	endtask
	task t_pin_reset;
		@(posedge i_sys_clk);
		want_q <= 1'b1;
		i_reset_pin_n <= 1'b0;
		wait_busy(1'b0, 8);
		wr(6'h03, 12'h777);
		load();
		wait_busy(1'b1, RST_CYC + 10);
		`CHK("len", 1'b1, (k >= RST_CYC - 8 && k <= RST_CYC + 2))
		`CHK("code0", 12'h000, code(0))
		`CHK("code3", 12'h000, code(3))
		cycles(10);
		`CHK("busy_n", 1'b1, o_busy_n)
		`CHK("qen", 1'b1, o_mode.queue_en)
		@(posedge i_sys_clk);
		i_reset_pin_n <= 1'b1;
	endtask
	task t_queue;
		@(posedge i_sys_clk);
		go <= 1'b1;
		for (int i = 0; i < 200; i++)
		begin
			instr <= '{channel: 6'h02, sel: MDUS_REG_DATA, value: 12'(i)};
			@(posedge i_sys_clk);
		end
		go <= 1'b0;
		@(negedge i_sys_clk);
		`CHK("full", 1'b1, o_queue_full)
		`CHK("busy_n", 1'b0, o_busy_n)
		@(posedge i_sys_clk);
		i_load_outputs_strobe_n <= 1'b0;
		wait_busy(1'b1, 1000);
		cycles(4);
		// one pop per compute plus idle cycle: write 197 is the last one taken
		`CHK("code2", 12'h0C5, code(2))
		`CHK("dropped", 1'b1, code(2) != 12'h0C7)
		@(posedge i_sys_clk);
		i_load_outputs_strobe_n <= 1'b1;
	endtask
	task t_power;
		@(posedge i_sys_clk);
		i_power_down <= 1'b1;
		cycles(3);
		`CHK("hiz", 2'b10, {o_outputs_hiz, o_outputs_pulldown})
		@(posedge i_sys_clk);
		i_powerdown_output_config_bit <= 1'b0;
		cycles(3);
		`CHK("pulldown", 2'b01, {o_outputs_hiz, o_outputs_pulldown})
		`CHK("kept", 12'h0C5, code(2))
		@(posedge i_sys_clk);
		i_power_down <= 1'b0;
	endtask
	task t_mode;
		for (int s = 0; s < 4; s++)
		begin
			@(posedge i_sys_clk);
			i_serial_parallel_select <= s[1];
			i_spi_i2c_select <= s[0];
			cycles(3);
			`CHK("mode", {~s[1], s[1] & s[0]}, {o_mode.parallel, o_mode.two_wire})
		end
		// serial mode: frame sync fall must wake the interface
		@(posedge i_sys_clk);
		sync_n <= 1'b0;
		cycles(3);
		`CHK("awake_sync", 1'b1, o_iface_awake)
		@(posedge i_sys_clk);
		sync_n <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		{i_rst_n, go, want_q, i_power_down, i_serial_parallel_select, i_spi_i2c_select} = '0;
		{i_reset_pin_n, i_async_clear_input_n, i_load_outputs_strobe_n, i_powerdown_output_config_bit, sync_n} = '1;
		i_clear_code = 12'h000;
		instr = '0;
		repeat (10) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		t_por();
		t_update();
		t_clear();
		t_pin_reset();
		t_queue();
		t_power();
		t_mode();
		close_out();
	end
endmodule
